// [rtl/exu_nmi_tlb_exception.v]
// Nmi entry, address error and translation exception detection and processing
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "exu_defines.vh"

module exu_nmi_tlb_exception
(
  input  wire        mclk,
  input  wire        arst_n,
  input  wire [3:0]  reg_addr,
  input  wire [63:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [63:0] reg_rdata,
  input  wire        nmi_pin_n,
  input  wire        sys_int_wr,
  input  wire        sys_bus_bit_six,
  input  wire        inst_boundary,
  input  wire [63:0] inst_pc,
  input  wire        inst_in_delay,
  input  wire        ftlb_hit,
  input  wire        ftlb_valid,
  input  wire        mem_valid,
  input  wire        mem_store,
  input  wire [1:0]  mem_size,
  input  wire [63:0] mem_vaddr,
  input  wire        dtlb_hit,
  input  wire        dtlb_valid,
  input  wire        dtlb_dirty,
  output reg         exc_taken,
  output reg  [63:0] exc_vector,
  output reg         nmi_pending,
  output reg  [4:0]  replace_index
);

  // Address region of a reference
  function [2:0] region_of;
    input [63:0] va;
    input        wide;
    begin
      region_of = `EXU_R_BAD;
      if (!wide)
      begin
        if (va[63:32] == {32{va[31]}})
        begin
          case (va[31:29])
            3'h4, 3'h5: region_of = `EXU_R_KUNM;
            3'h6:       region_of = `EXU_R_SUP;
            3'h7:       region_of = `EXU_R_KMAP;
            default:    region_of = `EXU_R_USR;
          endcase
        end
      end
      else
      begin
        case (va[63:62])
          2'h0: region_of = (va[61:40] == 22'h00_0000) ? `EXU_R_USR : `EXU_R_BAD;
          2'h1: region_of = (va[61:40] == 22'h00_0000) ? `EXU_R_SUP : `EXU_R_BAD;
          2'h2: region_of = `EXU_R_KUNM;
          default:
          begin
            if (va[61:40] == 22'h00_0000)
              region_of = `EXU_R_KMAP;
            else if (va[61:31] == {31{1'b1}})
              region_of = (va[30:29] == 2'h2) ? `EXU_R_SUP :
                          (va[30:29] == 2'h3) ? `EXU_R_KMAP : `EXU_R_KUNM;
          end
        endcase
      end
    end
  endfunction

  // Fault of one reference, by descending priority
  function [2:0] fault_of;
    input [63:0] va;
    input [1:0]  size;
    input        store;
    input        hit;
    input        valid;
    input        dirty;
    input [1:0]  priv;
    input        wide;
    reg   [2:0]  rg;
    reg          mis;
    reg          viol;
    begin
      rg   = region_of(va, wide);
      mis  = (size == 2'h1 && va[0]) || (size == 2'h2 && va[1:0] != 2'h0) ||
             (size == 2'h3 && va[2:0] != 3'h0);
      viol = (rg == `EXU_R_BAD) ||
             ((rg == `EXU_R_KMAP || rg == `EXU_R_KUNM) && priv != 2'h0) ||
             (rg == `EXU_R_SUP && priv == 2'h2);
      if (mis || viol)
        fault_of = `EXU_F_ADR;
      else if (rg == `EXU_R_KUNM)
        fault_of = `EXU_F_NONE;
      else if (!hit)
        fault_of = `EXU_F_MISS;
      else if (!valid)
        fault_of = `EXU_F_INV;
      else if (store && !dirty)
        fault_of = `EXU_F_MOD;
      else
        fault_of = `EXU_F_NONE;
    end
  endfunction

  reg  [22:0] status_q;
  reg  [31:0] cause_q;
  reg  [63:0] exc_ret_q;
  reg  [63:0] err_ret_q;
  reg  [63:0] badva_q;
  reg  [40:0] ctx_base_q;
  reg  [18:0] ctx_page_q;
  reg  [30:0] xctx_base_q;
  reg  [28:0] xctx_page_q;
  reg  [63:0] entry_hi_q;
  reg  [4:0]  wired_q;
  reg         nmi_s1_q;
  reg         nmi_s2_q;
  reg         nmi_s3_q;

  wire        exc_lvl  = status_q[`EXU_ST_EXC_LVL];
  wire        err_lvl  = status_q[`EXU_ST_ERR_LVL];
  wire [1:0]  priv     = (exc_lvl || err_lvl) ? 2'h0 : status_q[`EXU_ST_KSU];
  wire        cur_wide = (priv == 2'h2) ? status_q[`EXU_ST_USR_WIDE] :
                         (priv == 2'h1) ? status_q[`EXU_ST_SUP_WIDE] : status_q[`EXU_ST_KRN_WIDE];

  wire        nmi_fall = nmi_s3_q && !nmi_s2_q;
  wire        nmi_bus  = sys_int_wr && sys_bus_bit_six;
  wire        sw_nmi   = reg_wr && reg_addr == `EXU_REG_INTREG && reg_wdata[`EXU_INTREG_NMI];

  wire [2:0]  f_kind = fault_of(inst_pc, 2'h2, 1'b0, ftlb_hit, ftlb_valid, 1'b1, priv, cur_wide);
  wire [2:0]  d_kind = mem_valid ? fault_of(mem_vaddr, mem_size, mem_store, dtlb_hit, dtlb_valid,
                                            dtlb_dirty, priv, cur_wide) : `EXU_F_NONE;

  // Fetch faults outrank data faults
  wire        use_f  = (f_kind != `EXU_F_NONE);
  wire [2:0]  kind   = use_f ? f_kind : d_kind;
  wire [63:0] fva    = use_f ? inst_pc : mem_vaddr;
  wire        fstore = !use_f && mem_store;
  wire [2:0]  freg   = region_of(fva, cur_wide);
  wire        fwide  = (freg == `EXU_R_USR) ? status_q[`EXU_ST_USR_WIDE] :
                       (freg == `EXU_R_SUP) ? status_q[`EXU_ST_SUP_WIDE] : status_q[`EXU_ST_KRN_WIDE];

  // Nmi taken at the boundary whatever the level and enable bits
  wire        take_nmi = inst_boundary && nmi_pending;
  wire        take_exc = inst_boundary && !nmi_pending && kind != `EXU_F_NONE;

  reg  [4:0]  code;
  reg  [63:0] vec_d;

  always @*
  begin
    case (kind)
      `EXU_F_ADR: code = fstore ? `EXU_CODE_ST_ADR : `EXU_CODE_LD_ADR;
      `EXU_F_MOD: code = `EXU_CODE_MOD;
      default:    code = fstore ? `EXU_CODE_ST_XLT : `EXU_CODE_LD_XLT;
    endcase
    vec_d = status_q[`EXU_ST_BOOT_VEC] ? `EXU_VEC_BASE_BOOT : `EXU_VEC_BASE_RUN;
    if (take_nmi)
      vec_d = `EXU_VEC_RESET;
    else if (kind == `EXU_F_MISS && !exc_lvl)
      vec_d = vec_d + (fwide ? `EXU_OFS_MISS64 : `EXU_OFS_MISS32);
    else
      vec_d = vec_d + `EXU_OFS_COMMON;
  end

  // Two flops before the edge detector; pin idles high
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end
    else
    begin
      nmi_s1_q <= nmi_pin_n;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  // Pending request; a new request in the taking cycle wins
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      nmi_pending <= 1'b0;
    else if (nmi_fall || nmi_bus || sw_nmi)
      nmi_pending <= 1'b1;
    else if (take_nmi)
      nmi_pending <= 1'b0;
  end

  // Replacement index counts down, never below the wired floor
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      replace_index <= `EXU_RANDOM_RST;
      wired_q       <= `EXU_WIRED_RST;
    end
    else if (reg_wr && reg_addr == `EXU_REG_WIRED)
    begin
      wired_q       <= reg_wdata[4:0];
      replace_index <= `EXU_RANDOM_TOP;
    end
    else if (replace_index <= wired_q)
      replace_index <= `EXU_RANDOM_TOP;
    else
      replace_index <= replace_index - 5'h01;
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exc_taken  <= 1'b0;
      exc_vector <= `EXU_VEC_RESET;
    end
    else
    begin
      exc_taken  <= take_nmi || take_exc;
      exc_vector <= vec_d;
    end
  end

  // Software writes first; a same-cycle exception overrides them
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q    <= `EXU_STATUS_RST;
      cause_q     <= 32'h0000_0000;
      exc_ret_q   <= 64'h0000_0000_0000_0000;
      err_ret_q   <= 64'h0000_0000_0000_0000;
      badva_q     <= 64'h0000_0000_0000_0000;
      ctx_base_q  <= 41'h000_0000_0000;
      ctx_page_q  <= 19'h0_0000;
      xctx_base_q <= 31'h0000_0000;
      xctx_page_q <= 29'h0000_0000;
      entry_hi_q  <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `EXU_REG_STATUS:
            status_q <= (status_q & ~`EXU_STATUS_WMASK) | (reg_wdata[22:0] & `EXU_STATUS_WMASK);
          `EXU_REG_EXC_RET:  exc_ret_q   <= reg_wdata;
          `EXU_REG_ERR_RET:  err_ret_q   <= reg_wdata;
          `EXU_REG_CONTEXT:  ctx_base_q  <= reg_wdata[63:23];
          `EXU_REG_WIDE_PAGE_TABLE_POINTER: xctx_base_q <= reg_wdata[63:33];
          `EXU_REG_ENTRY_HI: entry_hi_q  <= reg_wdata;
          default: ;
        endcase
      end
      if (take_nmi)
      begin
        err_ret_q                  <= inst_pc;
        status_q[`EXU_ST_XLT_SHUT] <= 1'b0;
        status_q[`EXU_ST_ERR_LVL]  <= 1'b1;
        status_q[`EXU_ST_SOFT_NMI] <= 1'b1;
        status_q[`EXU_ST_BOOT_VEC] <= 1'b1;
      end
      else if (take_exc)
      begin
        status_q[`EXU_ST_EXC_LVL] <= 1'b1;
        cause_q[`EXU_CAUSE_CODE] <= code;
        badva_q                 <= fva;
        // Nested faults keep the first return address
        if (!exc_lvl)
        begin
          exc_ret_q                 <= inst_in_delay ? inst_pc - 64'h0000_0000_0000_0004 : inst_pc;
          cause_q[`EXU_CAUSE_BR_DLY] <= inst_in_delay;
        end
        // Page fields left stale on address errors, they are undefined
        if (kind != `EXU_F_ADR)
        begin
          ctx_page_q  <= fva[31:13];
          xctx_page_q <= {fva[63:62], fva[39:13]};
          entry_hi_q <= {fva[63:62], 22'h00_0000, fva[39:13], 5'h00, entry_hi_q[7:0]};
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 64'h0000_0000_0000_0000;
    else if (!reg_rd)
      reg_rdata <= 64'h0000_0000_0000_0000;
    else
    begin
      case (reg_addr)
        `EXU_REG_STATUS:   reg_rdata <= {41'h000_0000_0000, status_q};
        `EXU_REG_CAUSE:    reg_rdata <= {32'h0000_0000, cause_q};
        `EXU_REG_EXC_RET:  reg_rdata <= exc_ret_q;
        `EXU_REG_ERR_RET:  reg_rdata <= err_ret_q;
        `EXU_REG_BADVA:    reg_rdata <= badva_q;
        `EXU_REG_CONTEXT:  reg_rdata <= {ctx_base_q, ctx_page_q, 4'h0};
        `EXU_REG_WIDE_PAGE_TABLE_POINTER: reg_rdata <= {xctx_base_q, xctx_page_q, 4'h0};
        `EXU_REG_ENTRY_HI: reg_rdata <= entry_hi_q;
        `EXU_REG_RANDOM:   reg_rdata <= {59'h0, replace_index};
        `EXU_REG_WIRED:    reg_rdata <= {59'h0, wired_q};
        `EXU_REG_INTREG:   reg_rdata <= {57'h0, nmi_pending, 6'h00};
        default:           reg_rdata <= 64'h0000_0000_0000_0000;
      endcase
    end
  end

endmodule

// [rtl/exu_defines.vh]
// Constants of the nmi, address error and translation exception unit
// Operation
// - Falling nmi pin edge raises nmi
// - Bus write of bit six raises nmi
// - Nmi ignores exception level, error level, enable
// - Nmi fetches from the reset vector
// - Nmi taken only at instruction boundary
// - Nmi saves pc, clears translation shutdown
// - Nmi sets error level, soft flag, boot vector
// - Misaligned half, word, doubleword raises address error
// - Privileged or undefined space raises address error
// - Address error: common vector, load/store code
// - Address error captures faulting virtual address
// - Return address is faulting or branch instruction
// - Mapped reference without match raises miss
// - Miss vectors by width unless exception level
// - Miss and invalid record load/store code
// - Translation faults load address, keep space id
// - Matching invalid entry raises invalid exception
// - Store to clean valid entry raises modification
// - Replacement index points at usable slot
// - Vector base by boot bit plus offset
// - Only the highest priority exception reported
`ifndef EXU_DEFINES_VH
`define EXU_DEFINES_VH

// Register indices
`define EXU_REG_STATUS   4'h0
`define EXU_REG_CAUSE    4'h1
`define EXU_REG_EXC_RET  4'h2
`define EXU_REG_ERR_RET  4'h3
`define EXU_REG_BADVA    4'h4
`define EXU_REG_CONTEXT  4'h5
`define EXU_REG_WIDE_PAGE_TABLE_POINTER 4'h6
`define EXU_REG_ENTRY_HI 4'h7
`define EXU_REG_RANDOM   4'h8
`define EXU_REG_WIRED    4'h9
`define EXU_REG_INTREG   4'ha

// Status bit positions
`define EXU_ST_GIE      0
`define EXU_ST_EXC_LVL  1
`define EXU_ST_ERR_LVL  2
`define EXU_ST_KSU      4:3
`define EXU_ST_USR_WIDE 5
`define EXU_ST_SUP_WIDE 6
`define EXU_ST_KRN_WIDE 7
`define EXU_ST_SOFT_NMI 20
`define EXU_ST_XLT_SHUT 21
`define EXU_ST_BOOT_VEC 22
`define EXU_STATUS_RST 23'h40_0004
`define EXU_STATUS_WMASK 23'h70_00ff

// Cause fields and interrupt register nmi bit
`define EXU_CAUSE_BR_DLY 31
`define EXU_CAUSE_CODE 6:2
`define EXU_INTREG_NMI 6

// Exception codes
`define EXU_CODE_MOD  5'h01
`define EXU_CODE_LD_XLT 5'h02
`define EXU_CODE_ST_XLT 5'h03
`define EXU_CODE_LD_ADR 5'h04
`define EXU_CODE_ST_ADR 5'h05

// Vectors
`define EXU_VEC_RESET    64'hffff_ffff_bfc0_0000
`define EXU_VEC_BASE_RUN 64'hffff_ffff_8000_0000
`define EXU_VEC_BASE_BOOT 64'hffff_ffff_bfc0_0200
`define EXU_OFS_MISS32   64'h0000_0000_0000_0000
`define EXU_OFS_MISS64   64'h0000_0000_0000_0080
`define EXU_OFS_COMMON   64'h0000_0000_0000_0180

// Replacement index
`define EXU_RANDOM_TOP 5'h1f
`define EXU_RANDOM_RST 5'h1f
`define EXU_WIRED_RST  5'h00

// Fault kinds and regions
`define EXU_F_NONE 3'h0
`define EXU_F_ADR  3'h1
`define EXU_F_MISS 3'h2
`define EXU_F_INV  3'h3
`define EXU_F_MOD  3'h4
`define EXU_R_USR  3'h0
`define EXU_R_SUP  3'h1
`define EXU_R_KMAP 3'h2
`define EXU_R_KUNM 3'h3
`define EXU_R_BAD  3'h4

`endif

// [testbench/exu_checker.sv]
// Port assertions for the exception unit
`timescale 1ns/1ns
`include "exu_defines.vh"
module exu_checker
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        nmi_pin_n,
  input wire logic        sys_int_wr,
  input wire logic        sys_bus_bit_six,
  input wire logic        inst_boundary,
  input wire logic        mem_valid,
  input wire logic [1:0]  mem_size,
  input wire logic [63:0] mem_vaddr,
  input wire logic        dtlb_hit,
  input wire logic        exc_taken,
  input wire logic [63:0] exc_vector,
  input wire logic        nmi_pending,
  input wire logic [4:0]  replace_index
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence nmi_req_s;
    inst_boundary && nmi_pending && !sys_int_wr;
  endsequence
  sequence pin_fall_s;
    $fell(nmi_pin_n) && !nmi_pending;
  endsequence
  taken_cause_a: assert property (exc_taken |-> $past(inst_boundary))
    else $error("exception outside a boundary");
  nmi_entry_a: assert property (nmi_req_s |=> exc_taken && !nmi_pending
    && exc_vector == `EXU_VEC_RESET) else $error("nmi entry wrong");
  pin_nmi_a: assert property (pin_fall_s |-> ##[1:4] (nmi_pending || exc_taken))
    else $error("pin edge lost");
  sys_nmi_a: assert property (sys_int_wr && sys_bus_bit_six |=> nmi_pending)
    else $error("bus nmi lost");
  nmi_held_a: assert property (nmi_pending && !inst_boundary |=> nmi_pending)
    else $error("pending nmi dropped");
  vector_form_a: assert property (exc_taken |-> exc_vector == `EXU_VEC_RESET
    || (exc_vector[8:7] != 2'b10 && ((exc_vector & ~`EXU_OFS_COMMON) == `EXU_VEC_BASE_RUN
    || (exc_vector & ~`EXU_OFS_COMMON) == `EXU_VEC_BASE_BOOT))) else $error("bad vector");
  misalign_a: assert property (inst_boundary && mem_valid
    && (mem_vaddr[2:0] & ((3'h1 << mem_size) - 3'h1)) != 3'h0 |=> exc_taken) else $error("misalign missed");
  miss_a: assert property (inst_boundary && mem_valid && !dtlb_hit
    && mem_vaddr[63:31] == 33'h0_0000_0000 |=> exc_taken) else $error("miss missed");
  replace_step_a: assert property (1'b1 |=> replace_index == $past(replace_index) - 5'h01
    || replace_index == `EXU_RANDOM_TOP) else $error("replace index step");
endmodule

bind exu_nmi_tlb_exception exu_checker exu_checker_i (.mclk(mclk), .arst_n(arst_n), .nmi_pin_n(nmi_pin_n),
  .sys_int_wr(sys_int_wr), .sys_bus_bit_six(sys_bus_bit_six), .inst_boundary(inst_boundary),
  .mem_valid(mem_valid), .mem_size(mem_size), .mem_vaddr(mem_vaddr), .dtlb_hit(dtlb_hit),
  .exc_taken(exc_taken), .exc_vector(exc_vector), .nmi_pending(nmi_pending), .replace_index(replace_index));

// [testbench/exu_sys_model.sv]
// External system logic driving the nmi pin and the bus write
`timescale 1ns/1ns
module exu_sys_model
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic fire_pin,
  input  wire logic fire_bus,
  output logic      nmi_pin_n,
  output logic      sys_int_wr,
  output logic      sys_bus_bit_six
);
  logic [2:0] low_q;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_q           <= 3'h0;
      nmi_pin_n       <= 1'b1;
      sys_int_wr      <= 1'b0;
      sys_bus_bit_six <= 1'b0;
    end
    else
    begin
      // Pin held low for several cycles so the synchroniser sees it
      low_q           <= fire_pin ? 3'h5 : low_q - {2'h0, low_q != 3'h0};
      nmi_pin_n       <= !fire_pin && low_q <= 3'h1;
      sys_int_wr      <= fire_bus;
      // Released data bit toggles, a stale one must not request
      sys_bus_bit_six <= fire_bus | ~sys_bus_bit_six;
    end
  end
endmodule

// [testbench/test_nmi_address_tlb_exception_unit.sv]
// Self-checking bench for the nmi, address error and translation exception unit
`timescale 1ns/1ns
`include "exu_defines.vh"
module test_nmi_address_tlb_exception_unit;
  logic        mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, inst_boundary = 1'b0;
  logic        inst_in_delay = 1'b0, mem_valid = 1'b0, mem_store = 1'b0, fire_pin = 1'b0, fire_bus = 1'b0;
  logic        dtlb_hit = 1'b0, dtlb_valid = 1'b0, dtlb_dirty = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [1:0]  mem_size = 2'h0;
  logic [63:0] reg_wdata = 64'h0, inst_pc = 64'h0, mem_vaddr = 64'h0;
  logic [63:0] reg_rdata, exc_vector, pc, va, v, vec, ret, base, ofs;
  logic        nmi_pin_n, sys_int_wr, sys_bus_bit_six, exc_taken, nmi_pending, tk, dly, ae, tf;
  logic [4:0]  replace_index, code;
  logic [22:0] st;
  logic [23:0] op;
  int          errors = 0;
  int          n_compared = 0;
  int          seed = 92475;
  logic [22:0] t_st [11] = '{23'h0, 23'h0, 23'h0, 23'h10, 23'h0, 23'h20, 23'h2, 23'h40_0000, 23'h0, 23'h0, 23'h0};
  // Fields: kernel region, delay slot, store, size, offset, hit/valid/dirty
  logic [23:0] t_op [11] = '{24'h01_0227, 24'h00_1117, 24'h00_1347, 24'h10_0007, 24'h01_0000, 24'h00_1000,
                             24'h00_0000, 24'h00_1004, 24'h00_1006, 24'h00_1207, 24'h00_0220};

  exu_nmi_tlb_exception exu_nmi_tlb_exception_i
  (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin_n(nmi_pin_n), .sys_int_wr(sys_int_wr),
    .sys_bus_bit_six(sys_bus_bit_six), .inst_boundary(inst_boundary), .inst_pc(inst_pc),
    .inst_in_delay(inst_in_delay), .ftlb_hit(1'b1), .ftlb_valid(1'b1), .mem_valid(mem_valid),
    .mem_store(mem_store), .mem_size(mem_size), .mem_vaddr(mem_vaddr), .dtlb_hit(dtlb_hit),
    .dtlb_valid(dtlb_valid), .dtlb_dirty(dtlb_dirty), .exc_taken(exc_taken), .exc_vector(exc_vector),
    .nmi_pending(nmi_pending), .replace_index(replace_index)
  );
  exu_sys_model exu_sys_model_i (.mclk(mclk), .arst_n(arst_n), .fire_pin(fire_pin), .fire_bus(fire_bus),
    .nmi_pin_n(nmi_pin_n), .sys_int_wr(sys_int_wr), .sys_bus_bit_six(sys_bus_bit_six));

  always #50 mclk = ~mclk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [63:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [63:0] e);
    logic [63:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic pick();
    pc = {32'h0, 32'h0040_0000 | (32'($random(seed)) & 32'h000f_fffc)};
    va = op[20] ? 64'hffff_ffff_8000_0000 : 64'h0;
    va[28:3] = 26'($random(seed));
    va[2:0] = op[6:4];
  endtask
  task automatic step(output logic t, output logic [63:0] x);
    @(posedge mclk);
    inst_pc <= pc;
    inst_in_delay <= op[16];
    mem_valid <= 1'b1;
    mem_store <= op[12];
    mem_size <= op[9:8];
    mem_vaddr <= va;
    {dtlb_hit, dtlb_valid, dtlb_dirty} <= op[2:0];
    inst_boundary <= 1'b1;
    @(posedge mclk);
    inst_boundary <= 1'b0;
    mem_valid <= 1'b0;
    @(negedge mclk);
    t = exc_taken;
    x = exc_vector;
  endtask
  task summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk(64'(replace_index), 64'h1f);
    rd(`EXU_REG_STATUS, v);
    chk(64'(v[22:0]), 64'(`EXU_STATUS_RST));
    wr(`EXU_REG_WIRED, 64'h1c);
    for (int i = 0; i < 11; i++)
    begin
      st = t_st[i];
      op = t_op[i];
      wr(`EXU_REG_STATUS, 64'(st));
      pick();
      // Expected priority, code and vector
      ae = ((va[2:0] & ((3'h1 << op[9:8]) - 3'h1)) != 3'h0) || (st[4:3] == 2'b10 && va[63]);
      tf = !op[2] || !op[1] || (op[12] && !op[0]);
      code = ae ? `EXU_CODE_LD_ADR + 5'(op[12]) : (op[2] && op[1]) ? `EXU_CODE_MOD : `EXU_CODE_LD_XLT + 5'(op[12]);
      ofs = (!ae && !op[2] && !st[1]) ? (st[5] ? `EXU_OFS_MISS64 : `EXU_OFS_MISS32) : `EXU_OFS_COMMON;
      base = st[22] ? `EXU_VEC_BASE_BOOT : `EXU_VEC_BASE_RUN;
      // A nested fault keeps the first return address
      if (!st[1] && (ae || tf))
      begin
        ret = op[16] ? pc - 64'h4 : pc;
        dly = op[16];
      end
      step(tk, vec);
      chk(64'(tk), 64'(ae || tf));
      chk(64'(replace_index >= 5'h1c), 64'h1);
      if (ae || tf)
      begin
        chk(vec, base + ofs);
        rd(`EXU_REG_CAUSE, v);
        chk(64'({v[31], v[6:2]}), 64'({dly, code}));
        rchk(`EXU_REG_EXC_RET, ret);
        rchk(`EXU_REG_BADVA, va);
        if (!ae)
        begin
          rd(`EXU_REG_CONTEXT, v);
          chk(64'(v[22:4]), 64'(va[31:13]));
        end
      end
      $display("test %0d done", i);
    end
    wr(`EXU_REG_BADVA, ~va);
    rchk(`EXU_REG_BADVA, va);
    rchk(4'hf, 64'h0);
    for (int s = 0; s < 3; s++)
    begin
      wr(`EXU_REG_STATUS, 64'h20_0003);
      if (s == 2)
        wr(`EXU_REG_INTREG, 64'h40);
      @(posedge mclk);
      fire_pin <= (s == 0);
      fire_bus <= (s == 1);
      @(posedge mclk);
      fire_pin <= 1'b0;
      fire_bus <= 1'b0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      chk(64'(nmi_pending), 64'h1);
      op = 24'h00_0220;
      pick();
      step(tk, vec);
      chk(64'(tk), 64'h1);
      chk(vec, `EXU_VEC_RESET);
      chk(64'(nmi_pending), 64'h0);
      rchk(`EXU_REG_ERR_RET, pc);
      rchk(`EXU_REG_EXC_RET, ret);
      rd(`EXU_REG_STATUS, v);
      chk(64'(v[22:0]), 64'h50_0007);
      $display("nmi test %0d done", s);
    end
    summarize();
  end
endmodule
